// file: design/pmsc_pkg.sv
// pmsc_pkg: offsets, field positions, reset values and timing of the
// power-management sleep/SCI block.
// assumes a 125 MHz core clock and a 32 kHz RTC clock sampled as a pin.
`default_nettype none
package pmsc_pkg;
  // register offsets from the pm block base
  localparam logic [3:0] OFS_STATUS = 4'h1;
  localparam logic [3:0] OFS_ENABLE = 4'h3;
  localparam logic [3:0] OFS_CTRL1 = 4'h4;
  localparam logic [3:0] OFS_CTRL2 = 4'h5;
  localparam logic [3:0] OFS_GPE_STS = 4'h8;
  localparam logic [3:0] OFS_GPE_EN = 4'h9;
  // field positions
  localparam int BTN_BIT = 0;
  localparam int ALARM_BIT = 2;
  localparam int OVR_BIT = 3;
  localparam int SCI_MASTER_ENABLE_BIT = 0;
  localparam int OVR_EN_BIT = 1;
  localparam int TYPE_LSB = 2;
  localparam int TRIG_BIT = 5;
  localparam int PME_BIT = 0;
  // writable bits of each register, the rest read as zero
  localparam logic [7:0] ENABLE_MASK = 8'h05;
  localparam logic [7:0] CTRL1_MASK = 8'h01;
  localparam logic [7:0] CTRL2_MASK = 8'h1e;
  localparam logic [7:0] GPE_EN_MASK = 8'h01;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [2:0] SLEEP_TYPE_OFF = 3'h0;
  // timing
  localparam int CLK_HZ = 125000000;
  localparam int RTC_HZ = 32768;
  localparam int OVERRIDE_MS = 4000;
  localparam int OVERRIDE_CYC = OVERRIDE_MS * (CLK_HZ / 1000);
  // least delay of one rtc period, in core cycles, rounded up
  localparam int SLEEP_MIN_CYC = (CLK_HZ + RTC_HZ - 1) / RTC_HZ;
  localparam int SLEEP_TICKS = 2;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [3:0] addr;
    logic [7:0] wdata;
  } pmsc_io_req_s;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_WAIT_FIRST,
    SEQ_WAIT_SECOND
  } pmsc_seq_e;
endpackage
`default_nettype wire

// file: design/pmsc_sleep_sci.sv
// pmsc_sleep_sci: pm1 enables/control, sci, button override, sleep
// sequencing and pme summary status, reached through 8-bit i/o space.
// assumes button and rtc clock arrive as asynchronous pins; alarm and pme
// signals come from logic on core_clk_i.
`default_nettype none
module pmsc_sleep_sci #(
  parameter int OVERRIDE_CYC = pmsc_pkg::OVERRIDE_CYC
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire pmsc_pkg::pmsc_io_req_s io_req_i,
  output logic [7:0] io_rdata_o,
  input wire logic button_i,
  input wire logic rtc_clk_i,
  input wire logic alarm_i,
  input wire logic pme_event_i,
  input wire logic pme_pending_i,
  input wire logic sleep_redirect_select_i,
  output logic sci_o,
  output logic smi_o,
  output logic sleep_write_smi_flag_o,
  output logic power_on_output_n_o,
  output logic power_on_oe_o
);
  localparam int OVR_W = $clog2(OVERRIDE_CYC + 1);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers: a change counts once stages two and three agree
  logic [2:0] btn_sync_reg, btn_sync_next;
  logic [2:0] rtc_sync_reg, rtc_sync_next;
  logic btn_level_reg, btn_level_next;
  logic rtc_level_reg, rtc_level_next;
  logic btn_rise, rtc_tick;

  always_comb begin
    btn_sync_next = {btn_sync_reg[1:0], button_i};
    rtc_sync_next = {rtc_sync_reg[1:0], rtc_clk_i};
    btn_level_next = btn_level_reg;
    rtc_level_next = rtc_level_reg;
    if (btn_sync_reg[1] == btn_sync_reg[2]) begin
      btn_level_next = btn_sync_reg[2];
    end
    if (rtc_sync_reg[1] == rtc_sync_reg[2]) begin
      rtc_level_next = rtc_sync_reg[2];
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      btn_sync_reg <= 3'h0;
      rtc_sync_reg <= 3'h0;
      btn_level_reg <= 1'b0;
      rtc_level_reg <= 1'b0;
    end else begin
      btn_sync_reg <= btn_sync_next;
      rtc_sync_reg <= rtc_sync_next;
      btn_level_reg <= btn_level_next;
      rtc_level_reg <= rtc_level_next;
    end
  end

  assign btn_rise = btn_level_next & ~btn_level_reg;
  assign rtc_tick = rtc_level_next & ~rtc_level_reg;

  ////////////////////////////////////////////////////////////////////////
  // register writes
  function automatic logic wr_at(input pmsc_pkg::pmsc_io_req_s req,
                                 input logic [3:0] ofs);
    wr_at = req.wr && (req.addr == ofs);
  endfunction

  logic [7:0] enable_reg, enable_next;
  logic [7:0] ctrl1_reg, ctrl1_next;
  logic [7:0] ctrl2_reg, ctrl2_next;
  logic [7:0] gpe_en_reg, gpe_en_next;
  logic trig_wr;

  assign trig_wr = wr_at(io_req_i, pmsc_pkg::OFS_CTRL2)
                   && io_req_i.wdata[pmsc_pkg::TRIG_BIT];

  always_comb begin
    enable_next = enable_reg;
    ctrl1_next = ctrl1_reg;
    ctrl2_next = ctrl2_reg;
    gpe_en_next = gpe_en_reg;
    // reserved bits are masked so they always read zero
    if (wr_at(io_req_i, pmsc_pkg::OFS_ENABLE)) begin
      enable_next = io_req_i.wdata & pmsc_pkg::ENABLE_MASK;
    end
    if (wr_at(io_req_i, pmsc_pkg::OFS_CTRL1)) begin
      ctrl1_next = io_req_i.wdata & pmsc_pkg::CTRL1_MASK;
    end
    if (wr_at(io_req_i, pmsc_pkg::OFS_CTRL2)) begin
      // trigger bit is not stored
      ctrl2_next = io_req_i.wdata & pmsc_pkg::CTRL2_MASK;
    end
    if (wr_at(io_req_i, pmsc_pkg::OFS_GPE_EN)) begin
      gpe_en_next = io_req_i.wdata & pmsc_pkg::GPE_EN_MASK;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      enable_reg <= pmsc_pkg::REG_RESET;
      ctrl1_reg <= pmsc_pkg::REG_RESET;
      ctrl2_reg <= pmsc_pkg::REG_RESET;
      gpe_en_reg <= pmsc_pkg::REG_RESET;
    end else begin
      enable_reg <= enable_next;
      ctrl1_reg <= ctrl1_next;
      ctrl2_reg <= ctrl2_next;
      gpe_en_reg <= gpe_en_next;
    end
  end

  logic button_sci_enable, alarm_sci_enable, sci_master_enable;
  logic button_override_enable, pme_sci_enable;
  logic [2:0] sleep_type_field;
  assign button_sci_enable = enable_reg[pmsc_pkg::BTN_BIT];
  assign alarm_sci_enable = enable_reg[pmsc_pkg::ALARM_BIT];
  assign sci_master_enable = ctrl1_reg[pmsc_pkg::SCI_MASTER_ENABLE_BIT];
  assign button_override_enable = ctrl2_reg[pmsc_pkg::OVR_EN_BIT];
  assign sleep_type_field = ctrl2_reg[pmsc_pkg::TYPE_LSB +: 3];
  assign pme_sci_enable = gpe_en_reg[pmsc_pkg::PME_BIT];

  ////////////////////////////////////////////////////////////////////////
  // button override timer: saturates so the event fires once per hold
  logic [OVR_W-1:0] ovr_cnt_reg, ovr_cnt_next;
  logic ovr_fire;

  always_comb begin
    ovr_cnt_next = '0;
    if (btn_level_reg && button_override_enable) begin
      ovr_cnt_next = ovr_cnt_reg;
      if (ovr_cnt_reg != OVR_W'(OVERRIDE_CYC)) begin
        ovr_cnt_next = ovr_cnt_reg + 1'b1;
      end
    end
  end

  assign ovr_fire = btn_level_reg && button_override_enable
                    && ovr_cnt_reg == OVR_W'(OVERRIDE_CYC - 1);

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ovr_cnt_reg <= '0;
    end else begin
      ovr_cnt_reg <= ovr_cnt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status flags: set wins over a same-cycle write-one clear
  logic btn_flag_reg, btn_flag_next;
  logic alarm_flag_reg, alarm_flag_next;
  logic ovr_flag_reg, ovr_flag_next;
  logic pme_flag_reg, pme_flag_next;
  logic sts_wr, gpe_wr;

  assign sts_wr = wr_at(io_req_i, pmsc_pkg::OFS_STATUS);
  assign gpe_wr = wr_at(io_req_i, pmsc_pkg::OFS_GPE_STS);

  always_comb begin
    btn_flag_next = btn_flag_reg;
    alarm_flag_next = alarm_flag_reg;
    ovr_flag_next = ovr_flag_reg;
    pme_flag_next = pme_flag_reg;
    if (sts_wr) begin
      // only a one clears
      if (io_req_i.wdata[pmsc_pkg::BTN_BIT]) btn_flag_next = 1'b0;
      if (io_req_i.wdata[pmsc_pkg::ALARM_BIT]) alarm_flag_next = 1'b0;
      if (io_req_i.wdata[pmsc_pkg::OVR_BIT]) ovr_flag_next = 1'b0;
    end
    if (gpe_wr && io_req_i.wdata[pmsc_pkg::PME_BIT] && !pme_pending_i) begin
      pme_flag_next = 1'b0;
    end
    if (btn_rise) btn_flag_next = 1'b1;
    if (alarm_i) alarm_flag_next = 1'b1;
    if (pme_event_i) pme_flag_next = 1'b1;
    if (ovr_fire) begin
      btn_flag_next = 1'b0;
      ovr_flag_next = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      btn_flag_reg <= 1'b0;
      alarm_flag_reg <= 1'b0;
      ovr_flag_reg <= 1'b0;
      pme_flag_reg <= 1'b0;
    end else begin
      btn_flag_reg <= btn_flag_next;
      alarm_flag_reg <= alarm_flag_next;
      ovr_flag_reg <= ovr_flag_next;
      pme_flag_reg <= pme_flag_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sleep sequencing and power output
  pmsc_pkg::pmsc_seq_e seq_reg, seq_next;
  logic pwr_on_reg, pwr_on_next;
  logic smi_reg, smi_next;
  logic slp_smi_reg, slp_smi_next;
  logic sleep_go;

  // type comes from the same write as the trigger, as hosts set both at once
  assign sleep_go = trig_wr && !sleep_redirect_select_i
                    && io_req_i.wdata[pmsc_pkg::TYPE_LSB +: 3]
                       == pmsc_pkg::SLEEP_TYPE_OFF;

  always_comb begin
    seq_next = seq_reg;
    pwr_on_next = pwr_on_reg;
    smi_next = trig_wr && sleep_redirect_select_i;
    slp_smi_next = trig_wr;
    case (seq_reg)
      pmsc_pkg::SEQ_IDLE: begin
        if (sleep_go) seq_next = pmsc_pkg::SEQ_WAIT_FIRST;
      end
      pmsc_pkg::SEQ_WAIT_FIRST: begin
        if (rtc_tick) seq_next = pmsc_pkg::SEQ_WAIT_SECOND;
      end
      pmsc_pkg::SEQ_WAIT_SECOND: begin
        if (rtc_tick) begin
          seq_next = pmsc_pkg::SEQ_IDLE;
          pwr_on_next = 1'b0;
        end
      end
      default: seq_next = pmsc_pkg::SEQ_IDLE;
    endcase
    if (ovr_fire) pwr_on_next = 1'b0;
    // a button press always wakes the machine
    if (btn_rise) pwr_on_next = 1'b1;
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      seq_reg <= pmsc_pkg::SEQ_IDLE;
      pwr_on_reg <= 1'b1;
      smi_reg <= 1'b0;
      slp_smi_reg <= 1'b0;
    end else begin
      seq_reg <= seq_next;
      pwr_on_reg <= pwr_on_next;
      smi_reg <= smi_next;
      slp_smi_reg <= slp_smi_next;
    end
  end

  assign power_on_output_n_o = 1'b0;
  assign power_on_oe_o = pwr_on_reg;
  assign smi_o = smi_reg;
  assign sleep_write_smi_flag_o = slp_smi_reg;

  ////////////////////////////////////////////////////////////////////////
  // sci and read data
  logic sci_reg, sci_next;
  logic [7:0] rdata_reg, rdata_next;

  always_comb begin
    sci_next = sci_master_enable && (
                 (btn_flag_reg && button_sci_enable)
                 || (alarm_flag_reg && alarm_sci_enable)
                 || (pme_flag_reg && pme_sci_enable));
    rdata_next = rdata_reg;
    if (io_req_i.rd) begin
      rdata_next = 8'h00;
      case (io_req_i.addr)
        pmsc_pkg::OFS_STATUS: begin
          rdata_next[pmsc_pkg::BTN_BIT] = btn_flag_reg;
          rdata_next[pmsc_pkg::ALARM_BIT] = alarm_flag_reg;
          rdata_next[pmsc_pkg::OVR_BIT] = ovr_flag_reg;
        end
        pmsc_pkg::OFS_ENABLE: rdata_next = enable_reg;
        pmsc_pkg::OFS_CTRL1: rdata_next = ctrl1_reg;
        pmsc_pkg::OFS_CTRL2: rdata_next = ctrl2_reg;
        pmsc_pkg::OFS_GPE_STS: rdata_next[pmsc_pkg::PME_BIT] = pme_flag_reg;
        pmsc_pkg::OFS_GPE_EN: rdata_next = gpe_en_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sci_reg <= 1'b0;
      rdata_reg <= pmsc_pkg::REG_RESET;
    end else begin
      sci_reg <= sci_next;
      rdata_reg <= rdata_next;
    end
  end

  assign sci_o = sci_reg;
  assign io_rdata_o = rdata_reg;

  ////////////////////////////////////////////////////////////////////////
  // checks
  logic [15:0] slp_cyc_reg;
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) slp_cyc_reg <= 16'h0000;
    else if (seq_reg == pmsc_pkg::SEQ_IDLE) slp_cyc_reg <= 16'h0000;
    else if (slp_cyc_reg != 16'hffff) slp_cyc_reg <= slp_cyc_reg + 16'h0001;
  end

  property p_btn_set;
    @(posedge core_clk_i) disable iff (rst_i)
    btn_rise && !ovr_fire |=> btn_flag_reg && power_on_oe_o;
  endproperty
  a_btn_set: assert property (p_btn_set)
    else $error("button press did not set flag");

  property p_alarm_set;
    @(posedge core_clk_i) disable iff (rst_i)
    alarm_i |=> alarm_flag_reg;
  endproperty
  a_alarm_set: assert property (p_alarm_set)
    else $error("alarm did not set flag");

  property p_master_gate;
    @(posedge core_clk_i) disable iff (rst_i)
    !sci_master_enable |=> !sci_o;
  endproperty
  a_master_gate: assert property (p_master_gate)
    else $error("sci raised with master enable clear");

  property p_override;
    @(posedge core_clk_i) disable iff (rst_i)
    ovr_fire && !btn_rise |=> !power_on_oe_o && ovr_flag_reg
      && !btn_flag_reg;
  endproperty
  a_override: assert property (p_override)
    else $error("override did not power off and swap flags");

  property p_type_other;
    @(posedge core_clk_i) disable iff (rst_i)
    trig_wr && seq_reg == pmsc_pkg::SEQ_IDLE
      && io_req_i.wdata[pmsc_pkg::TYPE_LSB +: 3] != pmsc_pkg::SLEEP_TYPE_OFF
      |=> seq_reg == pmsc_pkg::SEQ_IDLE;
  endproperty
  a_type_other: assert property (p_type_other)
    else $error("non-off sleep type started a sequence");

  property p_sleep_min;
    @(posedge core_clk_i) disable iff (rst_i)
    seq_reg == pmsc_pkg::SEQ_WAIT_SECOND && rtc_tick
      |-> slp_cyc_reg >= 16'(pmsc_pkg::SLEEP_MIN_CYC - 8);
  endproperty
  a_sleep_min: assert property (p_sleep_min)
    else $error("power released before one rtc period");

  property p_trig_read;
    @(posedge core_clk_i) disable iff (rst_i)
    io_req_i.rd && io_req_i.addr == pmsc_pkg::OFS_CTRL2
      |=> !io_rdata_o[pmsc_pkg::TRIG_BIT] && io_rdata_o[7:5] == 3'h0;
  endproperty
  a_trig_read: assert property (p_trig_read)
    else $error("sleep trigger read back nonzero");

  property p_redirect;
    @(posedge core_clk_i) disable iff (rst_i)
    trig_wr && sleep_redirect_select_i && seq_reg == pmsc_pkg::SEQ_IDLE
      |=> smi_o && seq_reg == pmsc_pkg::SEQ_IDLE;
  endproperty
  a_redirect: assert property (p_redirect)
    else $error("redirected trigger did not raise smi");

  property p_slp_smi;
    @(posedge core_clk_i) disable iff (rst_i)
    trig_wr |=> sleep_write_smi_flag_o;
  endproperty
  a_slp_smi: assert property (p_slp_smi)
    else $error("trigger write did not flag smi");

  property p_pme_hold;
    @(posedge core_clk_i) disable iff (rst_i)
    pme_flag_reg && pme_pending_i |=> pme_flag_reg;
  endproperty
  a_pme_hold: assert property (p_pme_hold)
    else $error("pme flag cleared while events pending");

  property p_zero_write;
    @(posedge core_clk_i) disable iff (rst_i)
    sts_wr && alarm_flag_reg && !io_req_i.wdata[pmsc_pkg::ALARM_BIT]
      |=> alarm_flag_reg;
  endproperty
  a_zero_write: assert property (p_zero_write)
    else $error("zero write cleared a flag");

  property p_sci_level;
    @(posedge core_clk_i) disable iff (rst_i)
    ##1 sci_o == $past(sci_master_enable && ((btn_flag_reg
      && button_sci_enable) || (alarm_flag_reg && alarm_sci_enable)
      || (pme_flag_reg && pme_sci_enable)));
  endproperty
  a_sci_level: assert property (p_sci_level)
    else $error("sci does not follow enabled flags");
endmodule // pmsc_sleep_sci
`default_nettype wire

// file: testbench/pmsc_supply_model.sv
// pmsc_supply_model: system supply behind the power pin, and the free
// running 32 kHz standby clock that feeds the block.
// assumes the pin is open drain with a pull-up on the supply side.
`default_nettype none
module pmsc_supply_model (
  output logic rtc_clk_o,
  input wire logic power_on_oe_i,
  input wire logic power_on_output_n_i,
  output logic supply_on_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic pin_n;

  ////////////////////////////////////////////////////////////////////////
  // standby clock runs free, also while the system is off
  initial begin
    rtc_clk_o = 1'b0;
    forever #15258.789 rtc_clk_o = ~rtc_clk_o;
  end

  ////////////////////////////////////////////////////////////////////////
  // floated pin is pulled high, which the supply reads as off
  assign pin_n = power_on_oe_i ? power_on_output_n_i : 1'b1;
  assign supply_on_o = (pin_n === 1'b0);
endmodule // pmsc_supply_model
`default_nettype wire

// file: testbench/pmsc_sleep_sci_bench.sv
// pmsc_sleep_sci_bench: scenario tasks for the sleep and sci block.
// assumes pmsc_pkg is compiled first and the supply model beside it.
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
  fails++; $display("wrong value %s exp %0h got %0h", n, e, g); end end
module pmsc_sleep_sci_bench;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int OVR = 200;
  logic core_clk_i, rst_i, button_i, rtc_clk, alarm_i, pme_event_i;
  logic pme_pending_i, redirect, sci_o, smi_o, slp_o, pin_n, oe, supply_on;
  logic [7:0] io_rdata_o, rv;
  pmsc_pkg::pmsc_io_req_s req;
  int fails = 0;
  int check_count = 0;
  int slp_cnt = 0;
  int smi_cnt = 0;

  pmsc_sleep_sci #(.OVERRIDE_CYC(OVR)) dut (.core_clk_i(core_clk_i),
    .rst_i(rst_i), .io_req_i(req), .io_rdata_o(io_rdata_o),
    .button_i(button_i), .rtc_clk_i(rtc_clk), .alarm_i(alarm_i),
    .pme_event_i(pme_event_i), .pme_pending_i(pme_pending_i),
    .sleep_redirect_select_i(redirect), .sci_o(sci_o), .smi_o(smi_o),
    .sleep_write_smi_flag_o(slp_o), .power_on_output_n_o(pin_n),
    .power_on_oe_o(oe));
  pmsc_supply_model model (.rtc_clk_o(rtc_clk), .power_on_oe_i(oe),
    .power_on_output_n_i(pin_n), .supply_on_o(supply_on));

  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end
  // one-cycle pulses are counted where they stand
  always @(posedge core_clk_i) begin
    if (slp_o === 1'b1) slp_cnt++;
    if (smi_o === 1'b1) smi_cnt++;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // reserved bits are always written as zero by the host
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge core_clk_i);
    req <= '0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk_i);
    req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge core_clk_i);
    req <= '0;
    @(posedge core_clk_i);
    #1 d = io_rdata_o;
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  task automatic wait_supply(input logic v, input int lim);
    int i;
    for (i = 0; i < lim && supply_on !== v; i++) @(posedge core_clk_i);
    if (supply_on !== v) begin
      fails++;
      $display("wrong value supply_wait exp %0h got %0h", v, supply_on);
      summarize();
    end
  endtask
  task automatic press(input int n);
    button_i <= 1'b1;
    cycles(n);
    button_i <= 1'b0;
    cycles(8);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [3:0] ofs [6] = '{4'h1, 4'h3, 4'h4, 4'h5, 4'h8, 4'h9};
    logic [7:0] msk [6] = '{8'h00, 8'h05, 8'h01, 8'h1e, 8'h00, 8'h01};
    foreach (ofs[i]) begin
      rd(ofs[i], rv);
      `CHK("reset_value", 8'h00, rv)
      wr(ofs[i], msk[i]);
      rd(ofs[i], rv);
      `CHK("writable_bits", msk[i], rv)
      wr(ofs[i], 8'h00);
    end
    rd(4'h2, rv);
    `CHK("unmapped", 8'h00, rv)
    $display("test regs done");
  endtask
  task automatic t_button();
    press(10);
    rd(4'h1, rv);
    `CHK("button_flag", 8'h01, rv)
    wr(4'h3, 8'h01);
    cycles(3);
    `CHK("sci_no_master", 1'b0, sci_o)
    wr(4'h4, 8'h01);
    cycles(3);
    `CHK("sci_button", 1'b1, sci_o)
    wr(4'h1, 8'h00);
    rd(4'h1, rv);
    `CHK("flag_zero_write", 8'h01, rv)
    wr(4'h1, 8'h01);
    cycles(3);
    `CHK("sci_dropped", 1'b0, sci_o)
    $display("test button done");
  endtask
  task automatic t_alarm();
    alarm_i <= 1'b1;
    cycles(1);
    alarm_i <= 1'b0;
    cycles(3);
    rd(4'h1, rv);
    `CHK("alarm_flag", 8'h04, rv)
    `CHK("sci_alarm_off", 1'b0, sci_o)
    wr(4'h3, 8'h05);
    cycles(3);
    `CHK("sci_alarm", 1'b1, sci_o)
    wr(4'h4, 8'h00);
    cycles(3);
    `CHK("sci_master_off", 1'b0, sci_o)
    wr(4'h1, 8'h04);
    wr(4'h4, 8'h01);
    $display("test alarm done");
  endtask
  task automatic t_pme();
    pme_pending_i <= 1'b1;
    pme_event_i <= 1'b1;
    cycles(1);
    pme_event_i <= 1'b0;
    cycles(3);
    rd(4'h8, rv);
    `CHK("pme_flag", 8'h01, rv)
    `CHK("sci_pme_off", 1'b0, sci_o)
    wr(4'h9, 8'h01);
    cycles(3);
    `CHK("sci_pme", 1'b1, sci_o)
    wr(4'h8, 8'h01);
    rd(4'h8, rv);
    `CHK("pme_pending_hold", 8'h01, rv)
    pme_pending_i <= 1'b0;
    wr(4'h8, 8'h01);
    rd(4'h8, rv);
    `CHK("pme_cleared", 8'h00, rv)
    $display("test pme done");
  endtask
  task automatic t_sleep();
    realtime t0;
    wr(4'h5, 8'h24);
    rd(4'h5, rv);
    `CHK("trigger_reads_zero", 8'h04, rv)
    wr(4'h5, 8'h00);
    redirect <= 1'b1;
    wr(4'h5, 8'h20);
    redirect <= 1'b0;
    cycles(9000);
    `CHK("no_sleep", 1'b1, supply_on)
    `CHK("smi_count", 1, smi_cnt)
    `CHK("slp_count", 2, slp_cnt)
    wr(4'h5, 8'h20);
    t0 = $realtime;
    wait_supply(1'b0, 9000);
    `CHK("delay_min", 1'b1, ($realtime - t0) >= 30517.0)
    `CHK("delay_max", 1'b1, ($realtime - t0) <= 61100.0)
    press(10);
    `CHK("wake", 1'b1, supply_on)
    wr(4'h1, 8'h0d);
    $display("test sleep done");
  endtask
  task automatic t_override();
    wr(4'h5, 8'h02);
    button_i <= 1'b1;
    cycles(OVR / 2);
    `CHK("on_before_limit", 1'b1, supply_on)
    wait_supply(1'b0, OVR);
    button_i <= 1'b0;
    rd(4'h1, rv);
    `CHK("override_flags", 8'h08, rv)
    $display("test override done");
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst_i = 1'b1;
    req = '0;
    button_i = 1'b0;
    alarm_i = 1'b0;
    pme_event_i = 1'b0;
    pme_pending_i = 1'b0;
    redirect = 1'b0;
    repeat (20) @(posedge core_clk_i);
    rst_i <= 1'b0;
    cycles(2);
    `CHK("power_after_reset", 1'b1, supply_on)
    t_regs();
    t_button();
    t_alarm();
    t_pme();
    t_sleep();
    t_override();
    summarize();
  end
endmodule // pmsc_sleep_sci_bench
`undef CHK
`default_nettype wire
